// file: ssw_sync.sv
package ssw_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int NS_PER_MS = 1000000;
    localparam int RST_DELAY_MS = 200;
    localparam int WD_T0_MS = 100;
    localparam int WD_T1_MS = 500;
    localparam int WD_T2_MS = 1000;

    localparam logic [4:0] OFS_CTRL = 5'h00;
    localparam logic [4:0] OFS_STATE = 5'h04;
    localparam logic [4:0] OFS_INT_STATUS = 5'h08;
    localparam logic [4:0] OFS_INT_MASK = 5'h0c;
    localparam logic [4:0] OFS_WDOG_COUNT = 5'h10;

    localparam int CTRL_PEN_BIT = 7;
    localparam int CTRL_SEL_HI_BIT = 6;
    localparam int CTRL_SEL_LO_BIT = 5;
    localparam logic [7:0] CTRL_WR_MASK = 8'he0;
    localparam logic [7:0] CTRL_RESET = 8'h60;

    localparam int EV_UNDERVOLT = 0;
    localparam int EV_WDOG = 1;
    localparam int EV_SUPPLY2 = 2;
    localparam int EV_REFUSED = 3;
    localparam int EV_W = 4;

    localparam logic [1:0] SEL_T0 = 2'h0;
    localparam logic [1:0] SEL_T1 = 2'h1;
    localparam logic [1:0] SEL_T2 = 2'h2;
    localparam logic [1:0] SEL_OFF = 2'h3;

    typedef struct packed {
        logic supply_ok;
        logic supply2_ok;
        logic sda;
        logic scl;
        logic wp;
    } ssw_pins_t;

    typedef enum logic [1:0] {
        SSW_DELAY = 2'h1,
        SSW_RUN = 2'h3
    } ssw_state_t;
endpackage : ssw_pkg

module ssw_sync #(
    parameter int WIDTH = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= '0;
            sync_out <= '0;
        end else begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // ssw_sync

// file: ssw_top.sv
// Summary of operation
// - reset output is driven low whenever the main supply flag reports undervoltage.
// - after recovery reset stays low until the supply is good for the full delay, restarting on a dip.
// - from power-up reset is held low and released only after the delay of good supply.
// - an enabled watchdog with no start condition for its timeout asserts reset.
// - a falling data line while the clock line is high restarts the watchdog count.
// - three timeout choices are held in retained control bits that survive chip resets.
// - the second-supply fail pin is pulled low while that supply is below threshold, else released.
// - the second-supply fail pin has no delay and ignores the main reset logic.
// - the second-supply compare result reaches the pin with no hysteresis or filtering.
// - with the protect pin high and the protect enable bit set, control writes are refused.
// - the timeout comes from two control bits that software may rewrite unless locked.
// - while reset is active the two-wire bus is blocked and transfers are aborted.
module ssw_top
    import ssw_pkg::*;
#(
    parameter int RST_DELAY_CYC = RST_DELAY_MS * (NS_PER_MS / CLK_PERIOD_NS),
    parameter int WD_CYC0 = WD_T0_MS * (NS_PER_MS / CLK_PERIOD_NS),
    parameter int WD_CYC1 = WD_T1_MS * (NS_PER_MS / CLK_PERIOD_NS),
    parameter int WD_CYC2 = WD_T2_MS * (NS_PER_MS / CLK_PERIOD_NS)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic supply_ok_in,
    input wire logic supply2_monitor_in,
    input wire logic sda_in,
    input wire logic scl_in,
    input wire logic wp_in,
    output logic reset_out,
    output logic reset_oe_n,
    output logic supply2_fail_n,
    output logic supply2_fail_oe_n,
    output logic twowire_block,
    output logic irq
);
    localparam int CW = 32;

    generate
        if (RST_DELAY_CYC < 2 || WD_CYC0 < 2 || WD_CYC1 < 2 || WD_CYC2 < 2) begin : g_bad
            $error("ssw_top: delay and timeout counts must be at least 2");
        end
    endgenerate

    ssw_pins_t pins_raw;
    ssw_pins_t pins;
    logic sda_prev;
    logic start_cond;
    ssw_state_t state;
    logic [CW-1:0] dly_cnt;
    logic [CW-1:0] wd_cnt;
    logic [CW-1:0] wd_limit;
    logic wd_on;
    logic wd_expire;
    logic reset_active;
    logic [7:0] ctrl;
    logic [1:0] period_sel;
    logic locked;
    logic [EV_W-1:0] int_status;
    logic [EV_W-1:0] int_mask;
    logic [EV_W-1:0] events;
    logic supply2_prev;
    logic setup_ph;
    logic access_wr;
    logic wr_ctrl;
    logic wr_status;
    logic wr_mask;
    logic addr_ok;
    logic [31:0] next_rdata;

    assign pins_raw = '{supply_ok: supply_ok_in, supply2_ok: supply2_monitor_in,
                        sda: sda_in, scl: scl_in, wp: wp_in};

    ssw_sync #(
        .WIDTH($bits(ssw_pins_t))
    ) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(pins_raw),
        .sync_out(pins)
    );

    // start condition detect
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sda_prev <= 1'b1;
        end else begin
            sda_prev <= pins.sda;
        end
    end

    assign start_cond = sda_prev && !pins.sda && pins.scl;

    assign period_sel = {ctrl[CTRL_SEL_HI_BIT], ctrl[CTRL_SEL_LO_BIT]};
    assign wd_on = (period_sel != SEL_OFF);

    always_comb begin
        unique case (period_sel)
            SEL_T0: wd_limit = CW'(WD_CYC0);
            SEL_T1: wd_limit = CW'(WD_CYC1);
            SEL_T2: wd_limit = CW'(WD_CYC2);
            SEL_OFF: wd_limit = CW'(WD_CYC2);
        endcase
    end

    assign wd_expire = (state == SSW_RUN) && wd_on && !start_cond
        && (wd_cnt == wd_limit - CW'(1));

    // reset sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= SSW_DELAY;
        end else begin
            unique case (state)
                SSW_DELAY: begin
                    if (pins.supply_ok && dly_cnt == CW'(RST_DELAY_CYC - 1)) begin
                        state <= SSW_RUN;
                    end
                end
                SSW_RUN: begin
                    if (!pins.supply_ok) begin
                        state <= SSW_DELAY;
                    end else if (wd_expire) begin
                        state <= SSW_DELAY;
                    end
                end
                default: state <= SSW_DELAY;
            endcase
        end
    end

    // release delay counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly_cnt <= '0;
        end else if (state != SSW_DELAY || !pins.supply_ok) begin
            dly_cnt <= '0;
        end else if (dly_cnt != CW'(RST_DELAY_CYC - 1)) begin
            dly_cnt <= dly_cnt + CW'(1);
        end
    end

    // watchdog counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wd_cnt <= '0;
        end else if (state != SSW_RUN || !wd_on || start_cond || wd_expire) begin
            wd_cnt <= '0;
        end else begin
            wd_cnt <= wd_cnt + CW'(1);
        end
    end

    assign reset_active = (state != SSW_RUN);
    assign reset_out = 1'b0;
    // open drain low while in reset
    assign reset_oe_n = !reset_active;
    assign twowire_block = reset_active;

    assign supply2_fail_n = 1'b0;
    assign supply2_fail_oe_n = pins.supply2_ok;

    // apb decode
    assign setup_ph = psel && !penable;
    assign access_wr = psel && penable && pwrite;
    assign addr_ok = (paddr[31:5] == '0) && (paddr[1:0] == 2'h0)
        && (paddr[4:0] <= OFS_WDOG_COUNT);
    assign wr_ctrl = access_wr && (paddr[4:0] == OFS_CTRL);
    assign wr_status = access_wr && (paddr[4:0] == OFS_INT_STATUS);
    assign wr_mask = access_wr && (paddr[4:0] == OFS_INT_MASK);
    assign pready = 1'b1;

    assign locked = pins.wp && ctrl[CTRL_PEN_BIT];

    // retained control bits, untouched by chip reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
        end else if (wr_ctrl && !locked) begin
            ctrl <= pwdata[7:0] & CTRL_WR_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply2_prev <= 1'b0;
        end else begin
            supply2_prev <= pins.supply2_ok;
        end
    end

    always_comb begin
        events = '0;
        events[EV_UNDERVOLT] = (state == SSW_RUN) && !pins.supply_ok;
        events[EV_WDOG] = wd_expire;
        events[EV_SUPPLY2] = supply2_prev && !pins.supply2_ok;
        events[EV_REFUSED] = wr_ctrl && locked;
    end

    // sticky status, set wins over clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_status <= '0;
        end else if (wr_status) begin
            int_status <= (int_status & ~pwdata[EV_W-1:0]) | events;
        end else begin
            int_status <= int_status | events;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_mask <= '0;
        end else if (wr_mask) begin
            int_mask <= pwdata[EV_W-1:0];
        end
    end

    assign irq = |(int_status & int_mask);

    always_comb begin
        next_rdata = '0;
        unique case (paddr[4:0])
            OFS_CTRL: next_rdata[7:0] = ctrl;
            OFS_STATE: next_rdata[4:0] = {pins.wp, pins.supply2_ok, reset_active,
                                          wd_on, pins.supply_ok};
            OFS_INT_STATUS: next_rdata[EV_W-1:0] = int_status;
            OFS_INT_MASK: next_rdata[EV_W-1:0] = int_mask;
            OFS_WDOG_COUNT: next_rdata = wd_cnt;
            default: next_rdata = '0;
        endcase
    end

    // read data and error captured at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (setup_ph) begin
            prdata <= (addr_ok && !pwrite) ? next_rdata : 32'h0000_0000;
            pslverr <= !addr_ok || (pwrite && paddr[4:0] == OFS_CTRL && locked);
        end
    end

    property p_undervolt;
        @(posedge pclk) disable iff (!presetn)
        !pins.supply_ok |=> reset_active;
    endproperty
    a_undervolt: assert property (p_undervolt)
        else $error("undervoltage did not assert reset");

    property p_dip_restart;
        @(posedge pclk) disable iff (!presetn)
        (state == SSW_DELAY) && !pins.supply_ok |=> (dly_cnt == '0) && reset_active;
    endproperty
    a_dip_restart: assert property (p_dip_restart)
        else $error("supply dip did not restart delay");

    property p_release;
        @(posedge pclk) disable iff (!presetn)
        $fell(reset_active) |-> $past(dly_cnt) == CW'(RST_DELAY_CYC - 1)
            && $past(pins.supply_ok);
    endproperty
    a_release: assert property (p_release)
        else $error("reset released before full delay");

    property p_wdog_fire;
        @(posedge pclk) disable iff (!presetn)
        (state == SSW_RUN) && pins.supply_ok && wd_on && !start_cond
            && (wd_cnt == wd_limit - CW'(1)) |=> reset_active ##1 (dly_cnt == CW'(1));
    endproperty
    a_wdog_fire: assert property (p_wdog_fire)
        else $error("watchdog timeout did not reset");

    property p_wdog_kick;
        @(posedge pclk) disable iff (!presetn)
        start_cond |=> (wd_cnt == '0);
    endproperty
    a_wdog_kick: assert property (p_wdog_kick)
        else $error("start condition did not restart watchdog");

    property p_sup2;
        @(posedge pclk) disable iff (!presetn)
        $changed(supply2_fail_oe_n) |-> supply2_fail_oe_n == $past(supply2_monitor_in, 2)
            && !supply2_fail_n;
    endproperty
    a_sup2: assert property (p_sup2)
        else $error("fail pin does not follow second monitor");

    property p_lock;
        @(posedge pclk) disable iff (!presetn)
        wr_ctrl && locked |=> $stable(ctrl) && int_status[EV_REFUSED];
    endproperty
    a_lock: assert property (p_lock)
        else $error("locked control write took effect");

    property p_ctrl_src;
        @(posedge pclk) disable iff (!presetn)
        !$stable(ctrl) |-> $past(wr_ctrl) && !$past(locked);
    endproperty
    a_ctrl_src: assert property (p_ctrl_src)
        else $error("control bits changed without unlocked write");

    property p_block;
        @(posedge pclk) disable iff (!presetn)
        reset_active |-> twowire_block && !reset_oe_n;
    endproperty
    a_block: assert property (p_block)
        else $error("bus not blocked during reset");

    property p_wd_count;
        @(posedge pclk) disable iff (!presetn)
        (state == SSW_RUN) && pins.supply_ok && wd_on && !start_cond
            && (wd_cnt < wd_limit - CW'(1)) |=> wd_cnt == $past(wd_cnt) + CW'(1);
    endproperty
    a_wd_count: assert property (p_wd_count)
        else $error("watchdog counter did not advance");
endmodule // ssw_top

// file: ssw_host.sv
module ssw_host (
    output logic sda,
    output logic scl
);
    timeunit 1ns;
    timeprecision 1ps;

    // pulled-up lines idle high; link clock stands still between frames
    initial begin
        sda = 1'b1;
        scl = 1'b1;
    end

    // start condition, 200 ns link period
    task automatic send_start();
        #13 sda = 1'b0;
        #100 scl = 1'b0;
        #100 sda = 1'b1;
        #100 scl = 1'b1;
    endtask
endmodule // ssw_host

// file: ssw_bench.sv
module ssw_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import ssw_pkg::*;
    localparam int RD = 20;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready, pslverr, sda, scl, reset_out, reset_oe_n;
    logic supply2_fail_n, supply2_fail_oe_n, twowire_block, irq;
    logic supply_ok_in = 1'b1;
    logic supply2_monitor_in = 1'b1;
    logic wp_in = 1'b0;
    int failures = 0;
    int checks_done = 0;
    int n;
    int lim[3] = '{30, 50, 80};
    logic [31:0] rd;
    logic [31:0] seed = 32'h0daa;
    logic [31:0] model_ctrl;
    logic er;

    always #12.5 pclk = ~pclk;

    ssw_host ssw_host_inst (.sda(sda), .scl(scl));
    ssw_top #(.RST_DELAY_CYC(RD), .WD_CYC0(30), .WD_CYC1(50), .WD_CYC2(80)) ssw_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .supply_ok_in(supply_ok_in), .supply2_monitor_in(supply2_monitor_in), .sda_in(sda),
        .scl_in(scl), .wp_in(wp_in), .reset_out(reset_out), .reset_oe_n(reset_oe_n),
        .supply2_fail_n(supply2_fail_n), .supply2_fail_oe_n(supply2_fail_oe_n),
        .twowire_block(twowire_block), .irq(irq));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int v, input int lo, input int hi);
        checks_done++;
        if (v < lo || v > hi) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
        end
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge pclk);
    endtask

    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
        int t;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        if (t >= 50) begin
            failures++;
            complete_run();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_rst(input logic lvl, input int max);
        n = 0;
        while (reset_oe_n !== lvl) begin
            @(posedge pclk);
            n++;
            if (n > max) begin
                failures++;
                complete_run();
            end
        end
    endtask

    initial begin
        #1000000;
        failures++;
        complete_run();
    end

    initial begin
        model_ctrl = 32'(CTRL_RESET);
        cyc(8);
        presetn <= 1'b1;
        chk(twowire_block, 1'b1);
        chk(reset_out, 1'b0);
        wait_rst(1'b1, 40);
        chk_rng(n, RD, RD + 5);
        apb(1'b0, 32'(OFS_CTRL), 0);
        chk(rd, model_ctrl);
        apb(1'b0, 32'(OFS_STATE), 0);
        chk(rd, 32'h09);
        apb(1'b0, 32'(OFS_INT_STATUS), 0);
        chk(rd, 32'h0);
        apb(1'b0, 32'h14, 0);
        chk(rd, 32'h0);
        chk(er, 1'b1);
        cyc(100);
        chk(reset_oe_n, 1'b1);
        $display("test defaults done");
        wp_in <= 1'b1;
        foreach (lim[i]) begin
            model_ctrl = (i == 0) ? 32'h40 : (i == 1) ? 32'he0 : model_ctrl;
            apb(1'b1, 32'(OFS_CTRL), (i == 2) ? 32'h60 : model_ctrl);
            chk(er, i == 2);
        end
        apb(1'b0, 32'(OFS_CTRL), 0);
        chk(rd, model_ctrl);
        apb(1'b0, 32'(OFS_INT_STATUS), 0);
        chk(rd & 32'h8, 32'h8);
        wp_in <= 1'b0;
        cyc(4);
        model_ctrl = 32'h60;
        apb(1'b1, 32'(OFS_CTRL), model_ctrl);
        chk(er, 1'b0);
        $display("test protect done");
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            supply2_monitor_in <= seed[0];
            supply_ok_in <= (i < 12);
            cyc(3);
            chk(supply2_fail_oe_n, seed[0]);
        end
        chk(supply2_fail_n, 1'b0);
        supply2_monitor_in <= 1'b1;
        supply_ok_in <= 1'b1;
        wait_rst(1'b1, RD + 10);
        $display("test supply2 done");
        foreach (lim[s]) begin
            model_ctrl = 32'(s) << CTRL_SEL_LO_BIT;
            apb(1'b1, 32'(OFS_CTRL), model_ctrl);
            repeat (6) begin
                ssw_host_inst.send_start();
                cyc(5);
                chk(reset_oe_n, 1'b1);
            end
            wait_rst(1'b0, lim[s] + 20);
            chk_rng(n, lim[s] - 14, lim[s] + 2);
            chk(twowire_block, 1'b1);
            apb(1'b0, 32'(OFS_INT_STATUS), 0);
            chk(rd & 32'h2, 32'h2);
            apb(1'b1, 32'(OFS_INT_STATUS), 32'hf);
            wait_rst(1'b1, RD + 10);
            apb(1'b0, 32'(OFS_CTRL), 0);
            chk(rd, model_ctrl);
        end
        model_ctrl = 32'h60;
        apb(1'b1, 32'(OFS_CTRL), model_ctrl);
        $display("test watchdog done");
        supply_ok_in <= 1'b0;
        wait_rst(1'b0, 8);
        chk_rng(n, 1, 5);
        apb(1'b1, 32'(OFS_INT_MASK), 32'h1);
        cyc(1);
        chk(irq, 1'b1);
        supply_ok_in <= 1'b1;
        cyc(10);
        supply_ok_in <= 1'b0;
        cyc(3);
        supply_ok_in <= 1'b1;
        wait_rst(1'b1, RD + 20);
        chk_rng(n, RD, RD + 6);
        apb(1'b1, 32'(OFS_INT_STATUS), 32'hf);
        cyc(1);
        chk(irq, 1'b0);
        $display("test undervoltage done");
        complete_run();
    end
endmodule // ssw_bench
